// ==== rtl/rsc_consts.svh ====
// constants for the reset source controller: offsets, bit positions, reset values, timing
// Function
// - after any reset the watchdog runs, clocked by the system clock divided by twelve
// - watchdog overflow forces a system reset and sets the watchdog flag, bit 3
// - a flash read, write or erase at an illegal address forces a reset
// - programmer write or erase above the user code limit is a flash error
// - firmware code-memory data read above the user code limit is a flash error
// - instruction fetch above the user code limit is a flash error
// - flash access forbidden by the security setting is a flash error
// - flash write or erase while the supply monitor is off is a flash error
// - after a flash error reset bit 6 reads one; the bit is read only
// - writing one to bit 4 forces a reset; bit 4 then reads one
// - watchdog, flash error and software resets never drive the reset pin
// - bit 5 write enables comparator reset; read shows comparator caused last reset
// - bit 2 write enables the missing clock detector; read shows it caused reset
// - bit 1 reads one after power-on or supply reset; write selects supply monitor
// - while bit 1 reads one, the other cause flags carry no meaning
// - bit 0 reads one when the external pin caused the last reset; read only
// - detector resets when the clock stalls past its timeout; writing zero disables it
// - enabled comparator forces one reset when its plus input is below its minus input
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

`define RSC_ADDR_CAUSE 8'hEF
`define RSC_BIT_PIN 0
`define RSC_BIT_SUPPLY 1
`define RSC_BIT_CLKLOSS 2
`define RSC_BIT_WDOG 3
`define RSC_BIT_SOFT 4
`define RSC_BIT_CMP 5
`define RSC_BIT_FLASH 6
`define RSC_FLAGS_RESET 7'h02
`define RSC_WD_PRESCALE 12
`define RSC_WD_LIMIT 16'hFFFF
`define RSC_USER_LIMIT 16'hFBFF
`define RSC_HOLD_NS 128
`define RSC_CLK_NS 8
`define RSC_HOLD_CYCLES ((`RSC_HOLD_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_MCD_TIMEOUT_US 500
`define RSC_MCD_CYCLES ((`RSC_MCD_TIMEOUT_US * 1000) / `RSC_CLK_NS)

`endif

// ==== rtl/rsc_pkg.sv ====
// types shared by the reset source controller modules
package rsc_pkg;
   typedef enum logic [1:0] {
      RSC_FL_DATA_READ,
      RSC_FL_FETCH,
      RSC_FL_WRITE,
      RSC_FL_ERASE
   } rsc_flash_op_t;

   typedef enum logic [3:0] {
      RSC_CAUSE_NONE,
      RSC_CAUSE_POWER,
      RSC_CAUSE_PIN,
      RSC_CAUSE_SUPPLY,
      RSC_CAUSE_CLKLOSS,
      RSC_CAUSE_CMP,
      RSC_CAUSE_FLASH,
      RSC_CAUSE_WDOG,
      RSC_CAUSE_SOFT
   } rsc_cause_t;

   typedef enum {
      RSC_ST_RUN,
      RSC_ST_HOLD
   } rsc_state_t;
endpackage

// ==== rtl/rsc_wd_if.sv ====
// link between the sequencer and its watchdog timer
`timescale 1ns/1ps
interface rsc_wd_if;
   logic hold;
   logic stop;
   logic service;
   logic expired;
   logic running;

   modport ctrl (
      output hold,
      output stop,
      output service,
      input expired,
      input running
   );
   modport wdog (
      input hold,
      input stop,
      input service,
      output expired,
      output running
   );
endinterface

// ==== rtl/rsc_watchdog.sv ====
// watchdog timer: system clock divided by twelve feeding an overflow counter
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_watchdog #(
   parameter int PRESCALE = `RSC_WD_PRESCALE,
   parameter logic [15:0] LIMIT = `RSC_WD_LIMIT
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   rsc_wd_if.wdog wd
);
   logic [3:0] pre_ff;
   logic [15:0] cnt_ff;
   logic run_ff;
   logic exp_ff;
   logic tick;

   assign tick = (pre_ff == 4'(PRESCALE - 1));

   // enabled again by every reset; software may stop it afterwards
   always_ff @(posedge ref_clk) begin
      if (sys_rst || wd.hold) begin
         run_ff <= 1'b1;
      end else if (wd.stop) begin
         run_ff <= 1'b0;
      end
   end

   // divide by twelve prescaler
   always_ff @(posedge ref_clk) begin
      if (sys_rst || wd.hold || !run_ff || tick) begin
         pre_ff <= 4'h0;
      end else begin
         pre_ff <= pre_ff + 4'h1;
      end
   end

   // overflow counter, restarted by service
   always_ff @(posedge ref_clk) begin
      if (sys_rst || wd.hold || !run_ff || wd.service) begin
         cnt_ff <= 16'h0000;
      end else if (tick && cnt_ff != LIMIT) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   // one-cycle expiry pulse when the count reaches its limit
   always_ff @(posedge ref_clk) begin
      if (sys_rst || wd.hold) begin
         exp_ff <= 1'b0;
      end else begin
         exp_ff <= run_ff && !wd.service && tick && (cnt_ff == LIMIT - 16'h0001);
      end
   end

   assign wd.expired = exp_ff;
   assign wd.running = run_ff;
endmodule

// ==== rtl/rsc_top.sv ====
// reset source controller: gathers reset causes, holds system reset, records the cause
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_top #(
   parameter int HOLD_CYCLES = `RSC_HOLD_CYCLES,
   parameter int MCD_CYCLES = `RSC_MCD_CYCLES,
   parameter logic [15:0] USER_LIMIT = `RSC_USER_LIMIT,
   parameter int WD_PRESCALE = `RSC_WD_PRESCALE,
   parameter logic [15:0] WD_LIMIT = `RSC_WD_LIMIT
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic pin_rst_n_in,
   output logic pin_rst_n_out,
   output logic pin_rst_oe,
   input wire logic supply_low,
   input wire logic supply_monitor_enable,
   input wire logic cmp_plus_above,
   input wire logic clk_probe,
   input wire logic wdog_stop,
   input wire logic wdog_service,
   input wire logic flash_req,
   input wire rsc_pkg::rsc_flash_op_t flash_op,
   input wire logic flash_from_programmer,
   input wire logic [15:0] flash_addr,
   input wire logic flash_secure_deny,
   output logic system_reset,
   output logic wdog_running
);
   // overview of the sequencer
   // run state: every cycle the strongest pending cause is picked
   // hold state: system_reset stays high for a fixed count of cycles
   // a low reset pin stretches the hold until the pin is released
   // only a power-on hold pulls the pin, so internal causes stay local
   // the cause register is one-hot after every reset, so firmware
   // can tell what happened without decoding priorities itself
   // enables live apart from the flags: a write sets enables,
   // a read returns flags, and the two never mix on the bus
   // every reset drops the enables, so a source that is still
   // active after the hold cannot lock the part in reset forever
   // limitation: two causes in one cycle record only the strongest
   // limitation: the stall detector sees the clock only as sampled;
   // a real one-shot would work with no clock at all
   rsc_wd_if wd_link ();

   rsc_pkg::rsc_state_t state_ff;
   rsc_pkg::rsc_cause_t cause_ff;
   rsc_pkg::rsc_cause_t nxt_cause;
   logic [6:0] flags_ff;
   logic en_cmp_ff;
   logic en_mcd_ff;
   logic en_vdm_ff;
   logic [15:0] hold_cnt_ff;
   logic [31:0] mcd_cnt_ff;
   logic probe_last_ff;
   logic [7:0] rdata_ff;
   logic sysrst_ff;
   logic pin_oe_ff;
   logic wdrun_ff;
   logic wr_cause;
   logic flash_err;
   logic mcd_fault;

   // flash access check: an address above user space is illegal for all but programmer reads
   function automatic logic flash_bad(
      input rsc_pkg::rsc_flash_op_t op,
      input logic prog,
      input logic [15:0] addr,
      input logic deny,
      input logic vdm_on
   );
      logic above;
      logic modify;
      above = (addr > USER_LIMIT);
      modify = (op == rsc_pkg::RSC_FL_WRITE) || (op == rsc_pkg::RSC_FL_ERASE);
      flash_bad = 1'b0;
      if (prog && modify && above) begin
         flash_bad = 1'b1;
      end
      if (!prog && above) begin
         flash_bad = 1'b1;
      end
      if (deny) begin
         flash_bad = 1'b1;
      end
      if (modify && !vdm_on) begin
         flash_bad = 1'b1;
      end
      return flash_bad;
   endfunction

   assign wr_cause = sfr_wr && (sfr_addr == `RSC_ADDR_CAUSE) && (state_ff == rsc_pkg::RSC_ST_RUN);
   assign flash_err = flash_req && flash_bad(flash_op, flash_from_programmer, flash_addr,
      flash_secure_deny, supply_monitor_enable);
   assign mcd_fault = en_mcd_ff && (mcd_cnt_ff >= 32'(MCD_CYCLES));

   // watchdog link; its count restarts with every system reset
   assign wd_link.hold = sysrst_ff;
   assign wd_link.stop = wdog_stop;
   assign wd_link.service = wdog_service;

   rsc_watchdog #(
      .PRESCALE(WD_PRESCALE),
      .LIMIT(WD_LIMIT)
   ) u_wdog (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .wd(wd_link.wdog)
   );

   // priority order, strongest first:
   //    pin, supply, clock loss, comparator, flash, watchdog, software
   // the pin comes first because an outside master may hold the part
   // in reset for its own reasons and expects to see its own flag;
   // the supply comes next since logic is suspect while it is low;
   // the software request is last since firmware can simply retry it
   // cause selection, strongest source first so only one flag is set
   always_comb begin
      nxt_cause = rsc_pkg::RSC_CAUSE_NONE;
      if (!pin_rst_n_in) begin
         nxt_cause = rsc_pkg::RSC_CAUSE_PIN;
      end else if (en_vdm_ff && supply_low) begin
         nxt_cause = rsc_pkg::RSC_CAUSE_SUPPLY;
      end else if (mcd_fault) begin
         nxt_cause = rsc_pkg::RSC_CAUSE_CLKLOSS;
      end else if (en_cmp_ff && !cmp_plus_above) begin
         nxt_cause = rsc_pkg::RSC_CAUSE_CMP;
      end else if (flash_err) begin
         nxt_cause = rsc_pkg::RSC_CAUSE_FLASH;
      end else if (wd_link.expired) begin
         nxt_cause = rsc_pkg::RSC_CAUSE_WDOG;
      end else if (wr_cause && sfr_wdata[`RSC_BIT_SOFT]) begin
         nxt_cause = rsc_pkg::RSC_CAUSE_SOFT;
      end
   end

   // timing of one internal reset:
   //    edge 0: cause seen in run, state goes to hold, output rises
   //    edges 1 to HOLD_CYCLES-1: the hold counter runs down
   //    next edge: state back to run once the pin is high
   //    one edge later: the registered output falls
   // writes are refused during hold, so a slow firmware loop cannot
   // re-arm a source before the part has left reset
   // sequencer: run, or hold the system in reset for a fixed time
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_ff <= rsc_pkg::RSC_ST_HOLD;
         cause_ff <= rsc_pkg::RSC_CAUSE_POWER;
      end else begin
         case (state_ff)
            rsc_pkg::RSC_ST_RUN: begin
               if (nxt_cause != rsc_pkg::RSC_CAUSE_NONE) begin
                  state_ff <= rsc_pkg::RSC_ST_HOLD;
                  cause_ff <= nxt_cause;
               end
            end
            rsc_pkg::RSC_ST_HOLD: begin
               // a held pin keeps the part in reset until it is released
               if (hold_cnt_ff == 16'h0000 && pin_rst_n_in) begin
                  state_ff <= rsc_pkg::RSC_ST_RUN;
               end
            end
            default: begin
               state_ff <= rsc_pkg::RSC_ST_HOLD;
            end
         endcase
      end
   end

   // length of the reset pulse
   always_ff @(posedge ref_clk) begin
      if (sys_rst || state_ff == rsc_pkg::RSC_ST_RUN) begin
         hold_cnt_ff <= 16'(HOLD_CYCLES - 1);
      end else if (hold_cnt_ff != 16'h0000) begin
         hold_cnt_ff <= hold_cnt_ff - 16'h0001;
      end
   end

   // reset output straight from a flop
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sysrst_ff <= 1'b1;
      end else begin
         sysrst_ff <= (state_ff == rsc_pkg::RSC_ST_HOLD) ||
            (nxt_cause != rsc_pkg::RSC_CAUSE_NONE);
      end
   end

   // only power-on pulls the pin; internal sources leave it alone
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_oe_ff <= 1'b1;
      end else begin
         pin_oe_ff <= (state_ff == rsc_pkg::RSC_ST_HOLD) &&
            (cause_ff == rsc_pkg::RSC_CAUSE_POWER);
      end
   end

   // power-on leaves only the supply flag set; the other flags mean
   // nothing then, and clearing them keeps the read value tidy
   // the flags are written only on the edge that enters hold, so the
   // value stays put through the hold and the following run
   // cause flags: each reset writes a one-hot pattern, software cannot touch them
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flags_ff <= `RSC_FLAGS_RESET;
      end else if (state_ff == rsc_pkg::RSC_ST_RUN &&
         nxt_cause != rsc_pkg::RSC_CAUSE_NONE) begin
         flags_ff <= 7'h00;
         case (nxt_cause)
            rsc_pkg::RSC_CAUSE_PIN: flags_ff[`RSC_BIT_PIN] <= 1'b1;
            rsc_pkg::RSC_CAUSE_SUPPLY: flags_ff[`RSC_BIT_SUPPLY] <= 1'b1;
            rsc_pkg::RSC_CAUSE_CLKLOSS: flags_ff[`RSC_BIT_CLKLOSS] <= 1'b1;
            rsc_pkg::RSC_CAUSE_CMP: flags_ff[`RSC_BIT_CMP] <= 1'b1;
            rsc_pkg::RSC_CAUSE_FLASH: flags_ff[`RSC_BIT_FLASH] <= 1'b1;
            rsc_pkg::RSC_CAUSE_WDOG: flags_ff[`RSC_BIT_WDOG] <= 1'b1;
            rsc_pkg::RSC_CAUSE_SOFT: flags_ff[`RSC_BIT_SOFT] <= 1'b1;
            default: flags_ff <= 7'h00;
         endcase
      end
   end

   // a write that also forces a reset stores no enables: the hold
   // that follows would drop them anyway
   // source enables: written by software, dropped by every reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst || state_ff == rsc_pkg::RSC_ST_HOLD) begin
         en_cmp_ff <= 1'b0;
         en_mcd_ff <= 1'b0;
         en_vdm_ff <= 1'b0;
      end else if (wr_cause && nxt_cause == rsc_pkg::RSC_CAUSE_NONE) begin
         en_cmp_ff <= sfr_wdata[`RSC_BIT_CMP];
         en_mcd_ff <= sfr_wdata[`RSC_BIT_CLKLOSS];
         en_vdm_ff <= sfr_wdata[`RSC_BIT_SUPPLY];
      end
   end

   // the probe is a sampled copy of the watched clock; a stall shows
   // up as a probe that keeps one level for MCD_CYCLES samples
   // clock-stall detector: counts cycles since the probed clock last changed
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         probe_last_ff <= 1'b0;
      end else begin
         probe_last_ff <= clk_probe;
      end
   end

   // the counter saturates so a long stall cannot wrap back to quiet
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !en_mcd_ff || clk_probe != probe_last_ff) begin
         mcd_cnt_ff <= 32'h0000_0000;
      end else if (mcd_cnt_ff < 32'(MCD_CYCLES)) begin
         mcd_cnt_ff <= mcd_cnt_ff + 32'h0000_0001;
      end
   end

   // read data, one cycle after the strobe; bit 7 reads zero
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata_ff <= 8'h00;
      end else if (sfr_rd && sfr_addr == `RSC_ADDR_CAUSE) begin
         rdata_ff <= {1'b0, flags_ff};
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   // watchdog state mirrored through a flop
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wdrun_ff <= 1'b1;
      end else begin
         wdrun_ff <= wd_link.running;
      end
   end

   assign sfr_rdata = rdata_ff;
   assign system_reset = sysrst_ff;
   assign pin_rst_oe = pin_oe_ff;
   assign pin_rst_n_out = 1'b0;
   assign wdog_running = wdrun_ff;
endmodule

// ==== sim/rsc_top_props.sv ====
// concurrent port checks for the reset source controller
`timescale 1ns/1ps
module rsc_top_props #(
   parameter int HOLD_CYCLES = 16,
   parameter int MCD_CYCLES = 50,
   parameter logic [15:0] USER_LIMIT = 16'hFBFF
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic pin_rst_n_in,
   input wire logic pin_rst_n_out,
   input wire logic pin_rst_oe,
   input wire logic supply_monitor_enable,
   input wire logic flash_req,
   input wire rsc_pkg::rsc_flash_op_t flash_op,
   input wire logic flash_from_programmer,
   input wire logic [15:0] flash_addr,
   input wire logic flash_secure_deny,
   input wire logic system_reset,
   input wire logic wdog_running
);
   // one domain; reset silences every check
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   chk_soft_force:
   assert property (sfr_wr && sfr_addr == 8'hEF && sfr_wdata[4] && !system_reset
      |-> ##[1:2] system_reset) else $error("software write did not force reset");
   chk_flags_onehot:
   assert property ($onehot0(sfr_rdata)) else $error("more than one cause flag read");
   chk_pin_quiet:
   assert property ($rose(system_reset) |-> !pin_rst_oe [*4]) else $error("pin driven");
   chk_pin_low_only:
   assert property (pin_rst_oe |-> !pin_rst_n_out) else $error("pin driven high");
   chk_hold_min:
   assert property ($rose(system_reset) |-> system_reset [*8]) else $error("hold too short");
   chk_wd_restart:
   assert property ($fell(system_reset) |-> wdog_running) else $error("watchdog off");
   chk_fetch_err:
   assert property (flash_req && flash_op == rsc_pkg::RSC_FL_FETCH && !flash_from_programmer
      && flash_addr > USER_LIMIT && !system_reset |-> ##[1:2] system_reset)
      else $error("fetch above limit missed");
   chk_vdm_err:
   assert property (flash_req && flash_op[1] && !supply_monitor_enable && !system_reset
      |-> ##[1:2] system_reset) else $error("write with monitor off missed");
   chk_deny_err:
   assert property (flash_req && flash_secure_deny && !system_reset
      |-> ##[1:2] system_reset) else $error("denied access missed");
   chk_pin_reset:
   assert property (!pin_rst_n_in && !system_reset |-> ##[1:4] system_reset)
      else $error("pin reset missed");
   // main scenarios reached
   cover property (sfr_wr && sfr_wdata[4] && !system_reset);
   cover property (flash_req && !system_reset);
   cover property ($rose(system_reset) && !pin_rst_n_in);
endmodule

bind rsc_top rsc_top_props #(.HOLD_CYCLES(HOLD_CYCLES), .MCD_CYCLES(MCD_CYCLES),
   .USER_LIMIT(USER_LIMIT)) rsc_top_props_i (.*);

// ==== sim/tb_top.sv ====
// self-checking bench for the reset source controller
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, pin_rst_n_in = 1;
   logic [7:0] sfr_addr = 8'hEF, sfr_wdata = 8'h00, sfr_rdata;
   logic pin_rst_n_out, pin_rst_oe, system_reset, wdog_running;
   logic supply_low = 0, supply_monitor_enable = 1, cmp_plus_above = 1, clk_probe = 0;
   logic wdog_stop = 0, wdog_service = 0, flash_req = 0, flash_from_programmer = 0;
   logic flash_secure_deny = 0, probe_run = 1;
   logic [15:0] flash_addr = 16'h0000;
   rsc_pkg::rsc_flash_op_t flash_op = rsc_pkg::RSC_FL_DATA_READ;
   int n_fail = 0, comparisons = 0, cycles = 0;

   // short detector timeout keeps the stall test brief
   // small watchdog limit so an overflow fits in the run, yet no other
   // test leaves the watchdog running long enough to reach it
   rsc_top #(.MCD_CYCLES(50), .WD_LIMIT(16'h0040)) rsc_top_i (.*);

   // 8 ns system clock
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // monitored clock copy toggles unless a stall is wanted
   always @(posedge ref_clk) begin
      if (probe_run) clk_probe <= ~clk_probe;
   end
   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         final_report();
      end
   end

   task automatic final_report();
      if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // inputs move 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] d);
      sfr_wdata = d;
      sfr_wr = 1;
      tick(1);
      sfr_wr = 0;
   endtask
   task automatic rd(input logic [7:0] exp);
      sfr_rd = 1;
      tick(1);
      sfr_rd = 0;
      check(sfr_rdata, exp);
   endtask
   // bounded wait for the hold to end
   task automatic rel();
      int i;
      i = 0;
      while (system_reset !== 1'b0 && i < 60) begin
         tick(1);
         i++;
      end
      check({7'h00, system_reset}, 8'h00);
   endtask
   // internal causes must never pull the pin
   task automatic expect_reset(input logic exp, input int lim);
      logic hit;
      logic oe;
      hit = 0;
      oe = 0;
      repeat (lim) begin
         if (system_reset === 1'b1) hit = 1;
         if (pin_rst_oe !== 1'b0) oe = 1;
         tick(1);
      end
      check({7'h00, hit}, {7'h00, exp});
      check({7'h00, oe}, 8'h00);
      rel();
   endtask
   task automatic flash(input rsc_pkg::rsc_flash_op_t op, input logic prog,
         input logic [15:0] a, input logic deny, input logic vdm, input logic exp);
      flash_op = op;
      flash_from_programmer = prog;
      flash_addr = a;
      flash_secure_deny = deny;
      supply_monitor_enable = vdm;
      flash_req = 1;
      tick(1);
      flash_req = 0;
      flash_secure_deny = 0;
      supply_monitor_enable = 1;
      expect_reset(exp, 4);
      if (exp) rd(8'h40);
   endtask

   // main sequence
   initial begin
      tick(4);
      sys_rst = 0;
      rel();
      rd(8'h02);
      check({7'h00, wdog_running}, 8'h01);
      wr(8'h49);
      expect_reset(0, 6);
      rd(8'h02);
      wdog_stop = 1;
      tick(2);
      wdog_stop = 0;
      wr(8'h10);
      expect_reset(1, 4);
      rd(8'h10);
      check({7'h00, wdog_running}, 8'h01);
      flash(rsc_pkg::RSC_FL_WRITE, 1, 16'hFC00, 0, 1, 1);
      flash(rsc_pkg::RSC_FL_ERASE, 1, 16'hFC00, 0, 1, 1);
      flash(rsc_pkg::RSC_FL_DATA_READ, 0, 16'hFC00, 0, 1, 1);
      flash(rsc_pkg::RSC_FL_FETCH, 0, 16'hFFFF, 0, 1, 1);
      flash(rsc_pkg::RSC_FL_FETCH, 0, 16'hFBFF, 0, 1, 0);
      flash(rsc_pkg::RSC_FL_ERASE, 0, 16'h0000, 1, 1, 1);
      flash(rsc_pkg::RSC_FL_WRITE, 0, 16'h0100, 0, 0, 1);
      flash(rsc_pkg::RSC_FL_DATA_READ, 1, 16'hFC00, 0, 1, 0);
      cmp_plus_above = 0;
      expect_reset(0, 4);
      wr(8'h20);
      expect_reset(1, 4);
      cmp_plus_above = 1;
      rd(8'h20);
      wr(8'h04);
      tick(1);
      wr(8'h00);
      probe_run = 0;
      expect_reset(0, 80);
      wr(8'h04);
      expect_reset(1, 64);
      probe_run = 1;
      rd(8'h04);
      supply_low = 1;
      expect_reset(0, 4);
      wr(8'h02);
      expect_reset(1, 4);
      supply_low = 0;
      rd(8'h02);
      pin_rst_n_in = 0;
      tick(6);
      check({7'h00, system_reset}, 8'h01);
      pin_rst_n_in = 1;
      rel();
      rd(8'h01);
      expect_reset(1, 800);
      rd(8'h08);
      sys_rst = 1;
      tick(2);
      sys_rst = 0;
      rel();
      rd(8'h02);
      final_report();
   end
endmodule
